// ### dv/pipe_bus_model.sv
module pipe_bus_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic go,
    input wire logic go_wr,
    input wire logic [9:0] go_addr,
    input wire logic [31:0] go_data,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output logic [9:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable,
    output logic done,
    output logic rdata_valid_unused,
    output logic [31:0] rdata
);
    // Hold each request until waitrequest is seen low; scramble released lines so stale values never pass
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            read <= 1'h0;
            write <= 1'h0;
            done <= 1'h0;
            address <= 10'h3ff;
            writedata <= 32'h0;
            rdata <= 32'h0;
        end else if (go) begin
            read <= !go_wr;
            write <= go_wr;
            address <= go_addr;
            writedata <= go_data;
            done <= 1'h0;
        end else if ((read || write) && !waitrequest) begin
            read <= 1'h0;
            write <= 1'h0;
            rdata <= readdata;
            done <= 1'h1;
            address <= ~address;
            writedata <= ~writedata;
        end else begin
            done <= 1'h0;
        end
    end
    assign byteenable = 4'hf;
    assign rdata_valid_unused = done;
endmodule : pipe_bus_model

// ### dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic go = 1'h0;
    logic go_wr = 1'h0;
    logic [9:0] go_addr = 10'h000;
    logic [31:0] go_data = 32'h0;
    logic [9:0] address;
    logic [31:0] writedata, readdata, rdata;
    logic [3:0] byteenable;
    logic read, write, waitrequest, busy, done;
    int fail_count = 0;
    int comparisons = 0;
    logic [31:0] accm [64];
    logic [127:0] v1 = 128'h80ff_7f01_0203_fe80_10ff_0080_c3a5_5a01;
    logic [127:0] v2 = 128'hff80_8001_7f7f_0203_e0ff_1081_0102_fffe;
    logic [15:0] pr [8];
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 25 MHz; clock enable held on since it freezes the whole block
    always #20 clock = ~clock;
    int_outer_product_tile_mac int_outer_product_tile_mac_inst (.clock, .rst_n, .ce(1'h1), .address, .read,
        .write, .writedata, .byteenable, .readdata, .waitrequest, .busy);
    pipe_bus_model pipe_bus_model_inst (.clock, .rst_n, .go, .go_wr, .go_addr, .go_data, .waitrequest, .readdata,
        .address, .read, .write, .writedata, .byteenable, .done, .rdata_valid_unused(), .rdata);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp32
    // One bus transfer through the model; bounded so a stuck waitrequest ends the run
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clock);
        go <= 1'h1; go_wr <= wr; go_addr <= a; go_data <= d;
        @(posedge clock);
        go <= 1'h0;
        n = 0;
        #1;
        while (done !== 1'h1) begin
            if (n == 60) begin fail_count++; close_out(); end
            @(posedge clock); #1; n++;
        end
        q = rdata;
    endtask : xfer
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'h1, a, d, q);
    endtask : wr
    task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'h0, a, 32'h0, q);
        cmp32(q, exp);
    endtask : rdc
    task automatic check_acc;
        for (int i = 0; i < 64; i++) rdc(tile_mac_pkg::ACC_BASE + 10'(i * 4), accm[i]);
    endtask : check_acc
    ////////////////////////////////////////////////////////////////////////////////
    // Reference dot product: element widths, extension, masking and wrap kept independently of the design
    function automatic logic [63:0] dot(bit wide, bit mixed, int r, int c, logic [63:0] old, logic [15:0] m1,
                                        logic [15:0] m2);
        longint s, a, b, msk;
        int w;
        s = longint'(old);
        w = wide ? 16 : 8;
        msk = (longint'(1) << w) - 1;
        for (int k = 0; k < 4; k++) begin
            a = m1[(4 * r + k) * w / 8] ? longint'(v1 >> ((4 * r + k) * w)) & msk : 0;
            b = m2[(4 * c + k) * w / 8] ? longint'(v2 >> ((4 * c + k) * w)) & msk : 0;
            if (mixed && b > (msk >> 1)) b -= msk + 1;
            s = mixed ? s + a * b : s - a * b;
        end
        return wide ? 64'(s) : {32'h0, s[31:0]};
    endfunction : dot
    // Start one tile operation, time it, update the mirror and compare the whole array
    task automatic run_op(input bit mixed, input bit wide, input logic [2:0] tile, input logic [2:0] s1,
                          input logic [2:0] s2, input int cyc);
        logic [63:0] e;
        int n, wd, dim;
        dim = wide ? 2 : 4;
        wr(tile_mac_pkg::CTRL_OFS, {18'h0, 1'h1, 1'h1, s2, s1, tile, wide, mixed, 1'h1});
        n = 0;
        while (busy === 1'h1 && n < 40) begin @(posedge clock); #1; n++; end
        if (n == 40) begin fail_count++; close_out(); end
        cmp32(32'(n), 32'(cyc));
        for (int r = 0; r < dim; r++) begin
            for (int c = 0; c < dim; c++) begin
                wd = wide ? (tile * 4 + r * dim + c) * 2 : tile[1:0] * 16 + r * dim + c;
                e = dot(wide, mixed, r, c, {wide ? accm[wd + 1] : 32'h0, accm[wd]}, pr[s1], pr[s2]);
                accm[wd] = e[31:0];
                if (wide) accm[wd + 1] = e[63:32];
            end
        end
        rdc(tile_mac_pkg::STATUS_OFS, 32'h2);
        wr(tile_mac_pkg::STATUS_OFS, 32'hf);
        check_acc();
    endtask : run_op
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'h1;
        rdc(tile_mac_pkg::STATUS_OFS, 32'h0);
        rdc(tile_mac_pkg::FEATURE_OFS, 32'h1);
        for (int i = 0; i < 4; i++) wr(tile_mac_pkg::VEC1_BASE + 10'(i * 4), v1[i * 32 +: 32]);
        for (int i = 0; i < 4; i++) wr(tile_mac_pkg::VEC2_BASE + 10'(i * 4), v2[i * 32 +: 32]);
        for (int i = 0; i < 8; i++) begin
            pr[i] = 16'hffff >> i ^ 16'(i * 16'h1111);
            wr(tile_mac_pkg::PRED_BASE + 10'(i * 4), {16'hdead, pr[i]});
            rdc(tile_mac_pkg::PRED_BASE + 10'(i * 4), {16'h0, pr[i]});
        end
        for (int i = 0; i < 64; i++) begin
            accm[i] = 32'(i) * 32'h0404_0403 + 32'hffff_ff00;
            wr(tile_mac_pkg::ACC_BASE + 10'(i * 4), accm[i]);
        end
        wr(10'h200, 32'h1234_5678);
        rdc(10'h200, 32'h0);
        run_op(1'b0, 1'b0, 3'h3, 3'h1, 3'h6, 17);
        run_op(1'b1, 1'b0, 3'h0, 3'h0, 3'h2, 17);
        run_op(1'b1, 1'b1, 3'h7, 3'h3, 3'h0, 5);
        run_op(1'b0, 1'b1, 3'h4, 3'h0, 3'h5, 5);
        for (int i = 0; i < 2; i++) begin
            wr(tile_mac_pkg::CTRL_OFS, i == 0 ? 32'h1001 : 32'h2001);
            rdc(tile_mac_pkg::STATUS_OFS, 32'h8);
            wr(tile_mac_pkg::STATUS_OFS, 32'hf);
        end
        check_acc();
        close_out();
    end
endmodule : testbench

// ### dv/tile_mac_chk.sv
module tile_mac_chk #(
    parameter bit WIDE_INT_VARIANT_PRESENT = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Start strobe taken on the bus, and with both enables set
    logic go_ok;
    logic run_ok;
    assign go_ok = write && !waitrequest && ce && address == tile_mac_pkg::CTRL_OFS && writedata[0] && byteenable[0];
    assign run_ok = go_ok && writedata[12] && writedata[13];
    // Busy windows: narrow walks 16 elements plus commit, wide 4 plus commit
    sequence s_busy17;
        busy [*8] ##1 busy [*8] ##1 busy;
    endsequence
    sequence s_busy5;
        busy [*5];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_narrow_latency: assert property (run_ok && !writedata[2] |=> s_busy17 ##1 !busy)
        else $error("narrow busy window wrong");
    a_wide_latency: assert property (run_ok && writedata[2] && WIDE_INT_VARIANT_PRESENT |=> s_busy5 ##1 !busy)
        else $error("wide busy window wrong");
    a_trap_no_run: assert property (go_ok && !(writedata[12] && writedata[13]) |=> !busy [*3])
        else $error("start ran with an enable off");
    a_busy_cause: assert property ($rose(busy) |-> $past(run_ok))
        else $error("busy rose without a valid start");
    a_stall_busy: assert property (write && busy |-> waitrequest)
        else $error("write taken mid computation");
    a_first_wait: assert property ((read || write) && !$past(read || write) |-> waitrequest)
        else $error("request answered without wait cycle");
    a_read_answer: assert property (read && waitrequest && ce ##1 read |-> !waitrequest)
        else $error("read not answered in one cycle");
    a_rdata_hold: assert property (!$stable(readdata) |-> $past(read))
        else $error("read data moved without a read");
endmodule : tile_mac_chk

bind int_outer_product_tile_mac tile_mac_chk #(.WIDE_INT_VARIANT_PRESENT(WIDE_INT_VARIANT_PRESENT)) chk_inst (
    .clock, .rst_n, .ce, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .busy);

// ### rtl/int_outer_product_tile_mac.sv
module int_outer_product_tile_mac #(
    parameter bit WIDE_INT_VARIANT_PRESENT = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic busy
);

    // Register map, byte offsets, word aligned:
    //   CTRL    0x000 operation setup and start
    //   STATUS  0x004 busy (read only), done, undefined, trap
    //   FEATURE 0x008 bit 0 says whether the wide variant is built in
    //   VEC1    0x010 four words of the first operand vector, lane 0 lowest
    //   VEC2    0x020 four words of the second operand vector
    //   PRED    0x040 eight predicate words, upper half reads zero
    //   ACC     0x100 sixty-four words of accumulator array
    // Unmapped reads give zero and unmapped writes vanish, yet both are answered
    // so a stray access never hangs the bus.
    //
    // CTRL bits: 0 start (reads zero), 1 mixed-sign, 2 wide, 5:3 tile, 8:6 first
    //   mask, 11:9 second mask, 12 streaming enable, 13 array enable.
    // Tile placement: narrow tile t holds element r*4+c at word t*16+r*4+c, with
    //   the low two bits of t only; wide tile t holds element r*2+c as the word
    //   pair at (t*4+r*2+c)*2, low half first. Both widths alias one storage.
    // Predicates: narrow lane i is governed by bit i, wide lane i by bit 2*i,
    //   the lowest byte of the lane, so one predicate word serves both widths.
    // Wrap: every sum is taken modulo the element width, with no saturation
    //   and no overflow flag.
    //
    // Timing: every access waits one cycle. A start walks one tile element per
    // cycle (sixteen narrow, four wide) and commits the tile in one more cycle,
    // so the busy window depends on the variant alone, never on data or masks.
    // Trade-off: one dot-product unit keeps the area small at the cost of
    // throughput; software must poll busy or done between tiles.
    //
    // Hazard: writes stall while busy, so operands and masks cannot move under
    // a tile in flight; reads stay open and return the old array contents.

    typedef struct packed {
        tile_mac_pkg::mac_fsm_e fsm;
        logic ack;
        logic [31:0] rdata;
        logic op_mixed;
        logic op_wide;
        logic [2:0] tile;
        logic [2:0] sel1;
        logic [2:0] sel2;
        logic stream_en;
        logic array_en;
        logic busy;
        logic done;
        logic undef;
        logic trap;
        logic [3:0] cnt;
        logic [127:0] vec1;
        logic [127:0] vec2;
        logic [7:0][15:0] pred;
        logic [63:0][31:0] acc;
        logic [511:0] stage;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Merge write data into a word under the byte enables
    function automatic logic [31:0] merge_bytes(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // Pick element idx of a vector: byte lanes narrow, halfword lanes wide
    function automatic logic [15:0] lane_elem(logic [127:0] v, logic [3:0] idx, logic wide);
        logic [15:0] e;
        if (wide) begin
            e = v[{idx[2:0], 4'h0} +: 16];
        end else begin
            e = {8'h00, v[{idx, 3'h0} +: 8]};
        end
        return e;
    endfunction : lane_elem

    // Predicate bit governing element idx: one bit per byte, lowest byte of the lane
    function automatic logic lane_active(logic [15:0] p, logic [3:0] idx, logic wide);
        return wide ? p[{idx[2:0], 1'b0}] : p[idx];
    endfunction : lane_active

    // Widened product; the first operand is always unsigned
    function automatic logic [63:0] lane_product(logic [15:0] a, logic [15:0] b, logic wide, logic mixed);
        logic signed [16:0] ax;
        logic signed [16:0] bx;
        logic signed [33:0] p;
        ax = wide ? {1'b0, a} : {9'h000, a[7:0]};
        if (wide) begin
            bx = {mixed & b[15], b};
        end else begin
            bx = mixed ? {{9{b[7]}}, b[7:0]} : {9'h000, b[7:0]};
        end
        p = ax * bx;
        return {{30{p[33]}}, p};
    endfunction : lane_product

    // Address regions, shared by the read and write paths so both decode alike
    typedef enum logic [2:0] {
        RG_OTHER,
        RG_VEC1,
        RG_VEC2,
        RG_PRED,
        RG_ACC
    } region_e;

    function automatic region_e region_of(logic [9:0] a);
        region_e g;
        g = RG_OTHER;
        if (a[9:4] == tile_mac_pkg::VEC1_BASE[9:4]) begin
            g = RG_VEC1;
        end else if (a[9:4] == tile_mac_pkg::VEC2_BASE[9:4]) begin
            g = RG_VEC2;
        end else if (a[9:5] == tile_mac_pkg::PRED_BASE[9:5]) begin
            g = RG_PRED;
        end else if (a[9:8] == tile_mac_pkg::ACC_BASE[9:8]) begin
            g = RG_ACC;
        end
        return g;
    endfunction : region_of

    // Array word of tile element e; a wide element spans an even word and the odd one above
    function automatic logic [5:0] tile_word(logic [2:0] t, logic [3:0] e, logic wide, logic hi);
        logic [5:0] w;
        if (wide) begin
            w = {t, e[1:0], hi};
        end else begin
            w = {t[1:0], e};
        end
        return w;
    endfunction : tile_word

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle per access; writes stall while a tile is in flight

    assign waitrequest = (read | write) & ~(s_r.ack & ce);
    assign readdata = s_r.rdata;
    assign busy = s_r.busy;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [3:0] i1;
        logic [3:0] i2;
        logic [15:0] m1;
        logic [15:0] m2;
        logic [15:0] a;
        logic [15:0] b;
        logic [63:0] dot;
        logic [63:0] old;
        logic [63:0] newv;
        logic [5:0] aw;
        logic [3:0] last;
        logic [31:0] rd;
        logic wr_go;
        logic [31:0] cw;
        region_e rg;
        i1 = 4'h0;
        i2 = 4'h0;
        a = 16'h0000;
        b = 16'h0000;
        dot = 64'h0;
        old = 64'h0;
        newv = 64'h0;
        aw = 6'h00;
        rd = 32'h0000_0000;
        cw = 32'h0000_0000;
        rg = region_of(address);
        s_nxt = s_r;
        m1 = s_r.pred[s_r.sel1];
        m2 = s_r.pred[s_r.sel2];
        last = s_r.op_wide ? tile_mac_pkg::WIDE_LAST_ELEM : tile_mac_pkg::NARROW_LAST_ELEM;

        // Accept a request after one wait cycle; a write is held off while busy
        s_nxt.ack = (read | write) & ~s_r.ack & ~(write & s_r.busy);
        wr_go = write & s_r.ack;

        // Read decode, registered into the data flop on the wait cycle
        if (address == tile_mac_pkg::CTRL_OFS) begin
            rd[tile_mac_pkg::CTRL_MIXED_BIT] = s_r.op_mixed;
            rd[tile_mac_pkg::CTRL_WIDE_BIT] = s_r.op_wide;
            rd[tile_mac_pkg::CTRL_TILE_LSB +: 3] = s_r.tile;
            rd[tile_mac_pkg::CTRL_SEL1_LSB +: 3] = s_r.sel1;
            rd[tile_mac_pkg::CTRL_SEL2_LSB +: 3] = s_r.sel2;
            rd[tile_mac_pkg::CTRL_STREAM_BIT] = s_r.stream_en;
            rd[tile_mac_pkg::CTRL_ARRAY_BIT] = s_r.array_en;
        end else if (address == tile_mac_pkg::STATUS_OFS) begin
            rd[tile_mac_pkg::STAT_BUSY_BIT] = s_r.busy;
            rd[tile_mac_pkg::STAT_DONE_BIT] = s_r.done;
            rd[tile_mac_pkg::STAT_UNDEF_BIT] = s_r.undef;
            rd[tile_mac_pkg::STAT_TRAP_BIT] = s_r.trap;
        end else if (address == tile_mac_pkg::FEATURE_OFS) begin
            rd[0] = WIDE_INT_VARIANT_PRESENT;
        end else if (rg == RG_VEC1) begin
            rd = s_r.vec1[{address[3:2], 5'h00} +: 32];
        end else if (rg == RG_VEC2) begin
            rd = s_r.vec2[{address[3:2], 5'h00} +: 32];
        end else if (rg == RG_PRED) begin
            rd = {16'h0000, s_r.pred[address[4:2]]};
        end else if (rg == RG_ACC) begin
            rd = s_r.acc[address[7:2]];
        end
        if (read & ~s_r.ack) begin
            s_nxt.rdata = rd;
        end

        // Status flags are write-one-to-clear; sets below come later and win
        if (wr_go && address == tile_mac_pkg::STATUS_OFS && byteenable[0]) begin
            s_nxt.done = s_r.done & ~writedata[tile_mac_pkg::STAT_DONE_BIT];
            s_nxt.undef = s_r.undef & ~writedata[tile_mac_pkg::STAT_UNDEF_BIT];
            s_nxt.trap = s_r.trap & ~writedata[tile_mac_pkg::STAT_TRAP_BIT];
        end

        // Operand, predicate and array writes
        if (wr_go) begin
            if (rg == RG_VEC1) begin
                s_nxt.vec1[{address[3:2], 5'h00} +: 32] =
                    merge_bytes(s_r.vec1[{address[3:2], 5'h00} +: 32], writedata, byteenable);
            end else if (rg == RG_VEC2) begin
                s_nxt.vec2[{address[3:2], 5'h00} +: 32] =
                    merge_bytes(s_r.vec2[{address[3:2], 5'h00} +: 32], writedata, byteenable);
            end else if (rg == RG_PRED) begin
                cw = merge_bytes({16'h0000, s_r.pred[address[4:2]]}, writedata, byteenable);
                s_nxt.pred[address[4:2]] = cw[15:0];
            end else if (rg == RG_ACC) begin
                s_nxt.acc[address[7:2]] = merge_bytes(s_r.acc[address[7:2]], writedata, byteenable);
            end
        end

        // Control write; a start is only seen while idle since writes stall when busy
        if (wr_go && address == tile_mac_pkg::CTRL_OFS) begin
            cw = merge_bytes(rd, writedata, byteenable);
            s_nxt.op_mixed = cw[tile_mac_pkg::CTRL_MIXED_BIT];
            s_nxt.op_wide = cw[tile_mac_pkg::CTRL_WIDE_BIT];
            s_nxt.tile = cw[tile_mac_pkg::CTRL_TILE_LSB +: 3];
            s_nxt.sel1 = cw[tile_mac_pkg::CTRL_SEL1_LSB +: 3];
            s_nxt.sel2 = cw[tile_mac_pkg::CTRL_SEL2_LSB +: 3];
            s_nxt.stream_en = cw[tile_mac_pkg::CTRL_STREAM_BIT];
            s_nxt.array_en = cw[tile_mac_pkg::CTRL_ARRAY_BIT];
            if (byteenable[0] && writedata[tile_mac_pkg::CTRL_START_BIT]) begin
                if (!(cw[tile_mac_pkg::CTRL_STREAM_BIT] && cw[tile_mac_pkg::CTRL_ARRAY_BIT])) begin
                    s_nxt.trap = 1'b1;
                end else if (cw[tile_mac_pkg::CTRL_WIDE_BIT] && !WIDE_INT_VARIANT_PRESENT) begin
                    s_nxt.undef = 1'b1;
                end else begin
                    s_nxt.busy = 1'b1;
                    s_nxt.cnt = tile_mac_pkg::COUNT_RESET;
                    s_nxt.fsm = tile_mac_pkg::ST_CALC;
                end
            end
        end

        // One tile element per cycle into the staging buffer; nothing depends on data
        case (s_r.fsm)
            tile_mac_pkg::ST_IDLE: begin
            end
            tile_mac_pkg::ST_CALC: begin
                for (int k = 0; k < 4; k++) begin
                    if (s_r.op_wide) begin
                        i1 = {1'b0, s_r.cnt[1], 2'(k)};
                        i2 = {1'b0, s_r.cnt[0], 2'(k)};
                    end else begin
                        i1 = {s_r.cnt[3:2], 2'(k)};
                        i2 = {s_r.cnt[1:0], 2'(k)};
                    end
                    a = lane_active(m1, i1, s_r.op_wide) ? lane_elem(s_r.vec1, i1, s_r.op_wide) : 16'h0000;
                    b = lane_active(m2, i2, s_r.op_wide) ? lane_elem(s_r.vec2, i2, s_r.op_wide) : 16'h0000;
                    dot = dot + lane_product(a, b, s_r.op_wide, s_r.op_mixed);
                end
                // Tile placement: narrow tile t word t*16+e, wide tile t words (t*4+e)*2, +1
                if (s_r.op_wide) begin
                    aw = tile_word(s_r.tile, s_r.cnt, 1'b1, 1'b0);
                    old = {s_r.acc[tile_word(s_r.tile, s_r.cnt, 1'b1, 1'b1)], s_r.acc[aw]};
                end else begin
                    aw = tile_word(s_r.tile, s_r.cnt, 1'b0, 1'b0);
                    old = {32'h0000_0000, s_r.acc[aw]};
                end
                // Subtract for the unsigned form, add for the mixed form; both wrap
                newv = s_r.op_mixed ? old + dot : old - dot;
                if (s_r.op_wide) begin
                    s_nxt.stage[{s_r.cnt[1:0], 6'h00} +: 64] = newv;
                end else begin
                    s_nxt.stage[{s_r.cnt, 5'h00} +: 32] = newv[31:0];
                end
                s_nxt.cnt = s_r.cnt + 4'h1;
                if (s_r.cnt == last) begin
                    s_nxt.fsm = tile_mac_pkg::ST_COMMIT;
                end
            end
            tile_mac_pkg::ST_COMMIT: begin
                // Whole tile lands in one cycle so no partial result is ever visible
                for (int e = 0; e < 16; e++) begin
                    if (s_r.op_wide) begin
                        if (e < 4) begin
                            s_nxt.acc[tile_word(s_r.tile, 4'(e), 1'b1, 1'b0)] = s_r.stage[e*64 +: 32];
                            s_nxt.acc[tile_word(s_r.tile, 4'(e), 1'b1, 1'b1)] = s_r.stage[e*64+32 +: 32];
                        end
                    end else begin
                        s_nxt.acc[tile_word(s_r.tile, 4'(e), 1'b0, 1'b0)] = s_r.stage[e*32 +: 32];
                    end
                end
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.fsm = tile_mac_pkg::ST_IDLE;
            end
            default: begin
                s_nxt.fsm = tile_mac_pkg::ST_IDLE;
                s_nxt.busy = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; the enable freezes everything, including the bus handshake
    // A master must keep its request up across frozen cycles, since the answer
    // only comes on a cycle in which the enable is high.

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.fsm <= tile_mac_pkg::ST_IDLE;
            s_r.rdata <= tile_mac_pkg::RDATA_RESET;
            s_r.cnt <= tile_mac_pkg::COUNT_RESET;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

endmodule : int_outer_product_tile_mac

// ### rtl/tile_mac_pkg.sv
package tile_mac_pkg;

    // Datapath geometry
    localparam int VECTOR_LENGTH_BITS = 128;
    localparam int NARROW_ESIZE = 32;
    localparam int WIDE_ESIZE = 64;
    localparam int WORD_LANES_PER_VECTOR = VECTOR_LENGTH_BITS / NARROW_ESIZE;
    localparam int DOUBLEWORD_LANES_PER_VECTOR = VECTOR_LENGTH_BITS / WIDE_ESIZE;
    localparam int PRED_BITS = VECTOR_LENGTH_BITS / 8;
    localparam int ACC_WORDS = 64;
    localparam int STAGE_BITS = WORD_LANES_PER_VECTOR * WORD_LANES_PER_VECTOR * NARROW_ESIZE;

    // Cycle counts: one tile element per cycle, so latency depends on the variant only
    localparam logic [3:0] NARROW_LAST_ELEM = 4'(WORD_LANES_PER_VECTOR * WORD_LANES_PER_VECTOR - 1);
    localparam logic [3:0] WIDE_LAST_ELEM = 4'(DOUBLEWORD_LANES_PER_VECTOR * DOUBLEWORD_LANES_PER_VECTOR - 1);

    // Byte offsets on the register bus
    localparam logic [9:0] CTRL_OFS = 10'h000;
    localparam logic [9:0] STATUS_OFS = 10'h004;
    localparam logic [9:0] FEATURE_OFS = 10'h008;
    localparam logic [9:0] VEC1_BASE = 10'h010;
    localparam logic [9:0] VEC2_BASE = 10'h020;
    localparam logic [9:0] PRED_BASE = 10'h040;
    localparam logic [9:0] ACC_BASE = 10'h100;

    // Control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MIXED_BIT = 1;
    localparam int CTRL_WIDE_BIT = 2;
    localparam int CTRL_TILE_LSB = 3;
    localparam int CTRL_SEL1_LSB = 6;
    localparam int CTRL_SEL2_LSB = 9;
    localparam int CTRL_STREAM_BIT = 12;
    localparam int CTRL_ARRAY_BIT = 13;

    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_UNDEF_BIT = 2;
    localparam int STAT_TRAP_BIT = 3;

    // Values after reset
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [3:0] COUNT_RESET = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CALC,
        ST_COMMIT
    } mac_fsm_e;

endpackage : tile_mac_pkg
